// File: skip_eval.sv
`timescale 1ns/1ps
module skip_eval (
   skip_if.eval sif
);
   import skip_pkg::*;

   // ****************************************
   // Flag test decision
   // ****************************************
   // One line: test only while its control bit is 0, else a plain no-op
   function automatic logic line_skips(input logic hit, input logic ctl, input logic flg);
      line_skips = hit & ~ctl & flg;
   endfunction

   logic hit0;
   logic hit1;
   logic take0;
   logic take1;

   // Decode both instructions and test the selected flag
   always_comb begin
      hit0 = sif.exec & (sif.opcode == OPC_FLAG_TEST_0);
      hit1 = sif.exec & (sif.opcode == OPC_FLAG_TEST_1);
      take0 = line_skips(hit0, sif.ctrl[0], sif.flag[0]);
      take1 = line_skips(hit1, sif.ctrl[1], sif.flag[1]);
      sif.skip = take0 | take1;
      sif.clr = {take1, take0};
   end
endmodule

// File: skip_if.sv
`timescale 1ns/1ps
// Evaluator hook-up: decoded instruction in, skip decision out
interface skip_if;
   logic [9:0] opcode;
   logic exec;
   logic [1:0] ctrl;
   logic [1:0] flag;
   logic skip;
   logic [1:0] clr;
   modport eval (input opcode, exec, ctrl, flag, output skip, clr);
   modport core (output opcode, exec, ctrl, flag, input skip, clr);
endinterface

// File: skip_on_ext_irq_flag.sv
`timescale 1ns/1ps
module skip_on_ext_irq_flag (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic [skip_pkg::OPC_W-1:0] opcode,
   input wire logic instr_exec,
   input wire logic line0_request_flag,
   input wire logic line1_request_flag,
   output logic skip_req,
   output logic line0_flag_clr,
   output logic line1_flag_clr,
   input wire logic [skip_pkg::ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   import skip_pkg::*;

   // Bundle between this wrapper and the evaluator
   skip_if sif ();

   // ****************************************
   // State
   // ****************************************
   logic [CTRL_W-1:0] ctrl_q, ctrl_d;
   logic [CNT_W-1:0] cnt0_q, cnt0_d;
   logic [CNT_W-1:0] cnt1_q, cnt1_d;
   logic last_q, last_d;
   logic skip_q, skip_d;
   logic clr0_q, clr0_d;
   logic clr1_q, clr1_d;
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;
   logic access;
   logic mapped;

   // ****************************************
   // Evaluator
   // ****************************************
   // Control bits come straight from the register, no extra stage
   assign sif.opcode = opcode;
   assign sif.exec = instr_exec;
   assign sif.ctrl = {ctrl_q[LINE1_CTRL_POS], ctrl_q[LINE0_CTRL_POS]};
   assign sif.flag = {line1_request_flag, line0_request_flag};

   skip_eval u_eval (
      .sif(sif)
   );

   // ****************************************
   // Sequencer outputs
   // ****************************************
   // Strobes last one cycle per hit, longer on back-to-back hits; the flag owner lets a new set win over this clear
   always_comb begin
      skip_d = sif.skip;
      clr0_d = sif.clr[0];
      clr1_d = sif.clr[1];
      last_d = last_q;
      cnt0_d = cnt0_q;
      cnt1_d = cnt1_q;
      if (instr_exec) begin
         last_d = sif.skip;
      end
      if (sif.clr[0]) begin
         cnt0_d = cnt0_q + 8'h01; // Wraps, software takes differences
      end
      if (sif.clr[1]) begin
         cnt1_d = cnt1_q + 8'h01;
      end
   end

   // Strobe and statistics registers, constants only in reset
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         skip_q <= 1'b0;
         clr0_q <= 1'b0;
         clr1_q <= 1'b0;
         last_q <= 1'b0;
         cnt0_q <= CNT_RST;
         cnt1_q <= CNT_RST;
      end else begin
         skip_q <= skip_d;
         clr0_q <= clr0_d;
         clr1_q <= clr1_d;
         last_q <= last_d;
         cnt0_q <= cnt0_d;
         cnt1_q <= cnt1_d;
      end
   end

   // ****************************************
   // APB slave
   // ****************************************
   // One wait state so that read data and error leave from flops
   always_comb begin
      access = psel & penable & pready_q;
      mapped = (paddr == CTRL_OFS) | (paddr == STAT_OFS);
      pready_d = psel & penable & ~pready_q;
      pslverr_d = psel & penable & ~pready_q & ~mapped;
      prdata_d = 32'h0000_0000;
      if (psel & penable & ~pready_q & ~pwrite) begin
         if (paddr == CTRL_OFS) begin
            prdata_d[CTRL_W-1:0] = ctrl_q;
         end else if (paddr == STAT_OFS) begin
            prdata_d[STAT_CNT0_POS +: CNT_W] = cnt0_q;
            prdata_d[STAT_CNT1_POS +: CNT_W] = cnt1_q;
            prdata_d[STAT_LAST_POS] = last_q;
         end
      end
      ctrl_d = ctrl_q;
      if (access & pwrite & (paddr == CTRL_OFS)) begin
         ctrl_d = pwdata[CTRL_W-1:0];
      end
   end

   // Bus side registers; reset leaves both lines armed
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_q <= CTRL_RST;
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   // Every output leaves straight from a flop
   assign skip_req = skip_q;
   assign line0_flag_clr = clr0_q;
   assign line1_flag_clr = clr1_q;
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!nrst);

   // Instruction hits, decoded apart from the evaluator on purpose
   logic t0;
   logic t1;
   assign t0 = instr_exec && opcode == OPC_FLAG_TEST_0;
   assign t1 = instr_exec && opcode == OPC_FLAG_TEST_1;

   // Line 0: skip and clear only when armed and flagged
   skip0_set_a: assert property (
      t0 && !ctrl_q[0] && line0_request_flag |=> skip_req)
      else $error("line 0 test with flag set did not skip");
   clr0_pair_a: assert property (
      line0_flag_clr |-> skip_req && $past(t0) && $past(line0_request_flag))
      else $error("line 0 clear without its skip");
   clr0_only_a: assert property (
      t0 |=> !line1_flag_clr)
      else $error("line 0 test cleared line 1");
   skip0_none_a: assert property (
      t0 && !ctrl_q[0] && !line0_request_flag |=> !skip_req)
      else $error("line 0 test skipped with flag clear");
   nop0_ctl_a: assert property (
      t0 && ctrl_q[0] |=> !skip_req ##0 !line0_flag_clr)
      else $error("line 0 test acted while disabled");
   clr0_armed_a: assert property (
      line0_flag_clr |-> !$past(ctrl_q[0]))
      else $error("line 0 cleared while its control bit was set");

   // Line 1: same shape; back-to-back tests may stretch the clear
   skip1_set_a: assert property (
      t1 && !ctrl_q[1] && line1_request_flag |=> skip_req && !line0_flag_clr)
      else $error("line 1 test with flag set did not skip");
   skip1_none_a: assert property (
      t1 && !ctrl_q[1] && !line1_request_flag |=> !skip_req && !line1_flag_clr)
      else $error("line 1 test skipped with flag clear");
   clr1_pair_a: assert property (
      t1 && !ctrl_q[1] && line1_request_flag |=>
         line1_flag_clr ##1 (!line1_flag_clr || $past(t1)))
      else $error("line 1 clear not a single pulse after skip");
   clr1_src_a: assert property (
      line1_flag_clr |-> skip_req && $past(t1) && $past(line1_request_flag))
      else $error("line 1 clear without its skip");
   nop1_ctl_a: assert property (
      t1 && ctrl_q[1] |=> !skip_req && !line1_flag_clr)
      else $error("line 1 test acted while disabled");
   clr1_armed_a: assert property (
      line1_flag_clr |-> !$past(ctrl_q[1]))
      else $error("line 1 cleared while its control bit was set");

   // A skip always traces back to one of the two tests
   skip_src_a: assert property (
      skip_req |-> $past(t0) || $past(t1))
      else $error("skip without a flag test");

   // Control bit 0 moves only on a bus write and reads back in place
   ctrl_bit0_a: assert property (
      access && pwrite && paddr == CTRL_OFS |=>
         ctrl_q[LINE0_CTRL_POS] == $past(pwdata[LINE0_CTRL_POS]) ##1 $stable(ctrl_q))
      else $error("line 0 control bit not taken from bit 0");
   ctrl_hold_a: assert property (
      !(access && pwrite && paddr == CTRL_OFS) |=> $stable(ctrl_q))
      else $error("control register moved without a write");
   ctrl_read_a: assert property (
      pready && !pslverr && !pwrite && paddr == CTRL_OFS |->
         prdata[LINE0_CTRL_POS] == ctrl_q[LINE0_CTRL_POS])
      else $error("line 0 control bit read back wrong");
endmodule

// File: skip_pkg.sv
package skip_pkg;
   // ****************************************
   // Instruction encoding
   // ****************************************
   localparam int OPC_W = 10;
   localparam logic [9:0] OPC_FLAG_TEST_0 = 10'h038;
   localparam logic [9:0] OPC_FLAG_TEST_1 = 10'h039;

   // ****************************************
   // Register map and fields
   // ****************************************
   localparam int ADDR_W = 12;
   localparam logic [11:0] CTRL_OFS = 12'h000;
   localparam logic [11:0] STAT_OFS = 12'h004;
   localparam int CTRL_W = 4;
   localparam logic [3:0] CTRL_RST = 4'h0;
   localparam int LINE0_CTRL_POS = 0;
   localparam int LINE1_CTRL_POS = 1;
   localparam int CNT_W = 8;
   localparam int STAT_CNT0_POS = 0;
   localparam int STAT_CNT1_POS = 8;
   localparam int STAT_LAST_POS = 16;
   localparam logic [7:0] CNT_RST = 8'h00;
endpackage

// File: tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; \
   $display("unexpected at %0t: got %h exp %h", $time, (a), (b)); end end
module tb;
   import skip_pkg::*;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic instr_exec = 1'b0;
   logic f0 = 1'b0;
   logic f1 = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [9:0] opcode = 10'h000;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic skip_req, c0, c1, pready, pslverr, err;
   int miscompares = 0;
   int cmp_count = 0;

   skip_on_ext_irq_flag skip_on_ext_irq_flag_inst (
      .core_clk(core_clk), .nrst(nrst), .opcode(opcode), .instr_exec(instr_exec),
      .line0_request_flag(f0), .line1_request_flag(f1), .skip_req(skip_req),
      .line0_flag_clr(c0), .line1_flag_clr(c1), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr)
   );

   // ****************************************
   // Bus and instruction drivers
   // ****************************************
   // Waits on pready, never a fixed count, so slower slaves still pass
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // One instruction, then the pulse and its end are both checked
   task automatic run(input logic [9:0] op, input logic a, input logic b,
                      input logic [2:0] exp);
      @(posedge core_clk);
      opcode <= op;
      instr_exec <= 1'b1;
      f0 <= a;
      f1 <= b;
      @(posedge core_clk);
      instr_exec <= 1'b0;
      #1;
      `CHK({skip_req, c0, c1}, exp)
      @(posedge core_clk);
      #1;
      `CHK({skip_req, c0, c1}, 3'h0)
   endtask

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // ****************************************
   // Clock, watchdog and tests
   // ****************************************
   initial begin
      forever #2 core_clk = ~core_clk;
   end

   // Whole sequence takes well under 200 cycles
   initial begin
      #20000;
      miscompares++;
      close_out();
   end

   initial begin
      repeat (4) @(posedge core_clk);
      nrst <= 1'b1;
      #1;
      `CHK({skip_req, c0, c1}, 3'h0)
      apb(1'b0, CTRL_OFS, 32'h0);
      `CHK(rd[3:0], CTRL_RST)
      run(OPC_FLAG_TEST_0, 1'b1, 1'b1, 3'h6);
      run(OPC_FLAG_TEST_0, 1'b0, 1'b1, 3'h0);
      run(OPC_FLAG_TEST_1, 1'b1, 1'b1, 3'h5);
      run(OPC_FLAG_TEST_1, 1'b1, 1'b0, 3'h0);
      run(10'h03A, 1'b1, 1'b1, 3'h0);
      // Line 0 disabled: its test becomes a no-op, line 1 untouched
      apb(1'b1, CTRL_OFS, 32'h1);
      apb(1'b0, CTRL_OFS, 32'h0);
      `CHK(rd, 32'h1)
      run(OPC_FLAG_TEST_0, 1'b1, 1'b1, 3'h0);
      run(OPC_FLAG_TEST_1, 1'b1, 1'b1, 3'h5);
      // Line 1 disabled only
      apb(1'b1, CTRL_OFS, 32'h2);
      run(OPC_FLAG_TEST_1, 1'b1, 1'b1, 3'h0);
      run(OPC_FLAG_TEST_0, 1'b1, 1'b1, 3'h6);
      // Two skips per line so far, and the last test skipped
      apb(1'b0, STAT_OFS, 32'h0);
      `CHK(rd[15:0], 16'h0202)
      `CHK(rd[16], 1'b1)
      `CHK(err, 1'b0)
      // Unmapped address answers with an error and reads zero
      apb(1'b0, 12'h008, 32'h0);
      `CHK(err, 1'b1)
      `CHK(rd, 32'h0)
      close_out();
   end
endmodule
